// ### hdl/scs_consts.svh
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define SCS_IDX_MODE      10'h200
`define SCS_IDX_CMD       10'h202
`define SCS_IDX_IFLAG     10'h204
`define SCS_IDX_STATE     10'h206
`define SCS_IDX_DPORT     10'h208
`define SCS_IDX_DIP       10'h20a

// Mode register reset value and the bits that are implemented.
`define SCS_MODE_RST      16'h0000
`define SCS_MODE_MASK     16'h01af
`define SCS_PROTO_MSB     3
`define SCS_PROTO_LSB     0
`define SCS_PROTO_CLOSED  4'h0
`define SCS_PROTO_TCP     4'h1

// Command codes held in the low byte of the command register.
`define SCS_CMD_NONE      8'h00
`define SCS_CMD_OPEN      8'h01
`define SCS_CMD_LISTEN    8'h02
`define SCS_CMD_CONNECT   8'h04
`define SCS_CMD_DISCONNECT_COMMAND    8'h08

// Interrupt flag positions and reset value.
`define SCS_IF_CON        0
`define SCS_IF_DISCONNECT_COMMAND     1
`define SCS_IF_TIMEOUT    3
`define SCS_IFLAG_RST     8'h00
`define SCS_IFLAG_MASK    8'h0b

// Socket state codes as software reads them.
`define SCS_ST_CLOSED     8'h00
`define SCS_ST_ARP        8'h01
`define SCS_ST_INIT       8'h13
`define SCS_ST_LISTEN     8'h14
`define SCS_ST_SYNSENT    8'h15
`define SCS_ST_SYNRECV    8'h16
`define SCS_ST_ESTAB      8'h17
`define SCS_ST_FINWAIT    8'h18
`define SCS_ST_LASTACK    8'h1d
`define SCS_ST_OTHER      8'h22

// Timing: a microsecond tick derived from the 20 ns clock.
`define SCS_CLK_PERIOD_NS 20
`define SCS_TICK_NS       1000
`define SCS_TICK_CYC      (`SCS_TICK_NS / `SCS_CLK_PERIOD_NS)
`define SCS_TCP_TIMEOUT_US     200000

`endif

// ### hdl/scs_pkg.sv
package scs_pkg;

    // Connection sequencer states.
    typedef enum logic [3:0] {
        SCS_CLOSED,
        SCS_INIT,
        SCS_OTHER,
        SCS_LISTEN,
        SCS_SYNRECV,
        SCS_ARP,
        SCS_SYNSENT,
        SCS_ESTAB,
        SCS_FINWAIT,
        SCS_LASTACK
    } scs_state_t;

endpackage

// ### hdl/scs_timer.sv
`timescale 1ns/100ps
`include "scs_consts.svh"

module scs_timer #(
    parameter int unsigned LIMIT_US = `SCS_TCP_TIMEOUT_US
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic stop,
    output logic      expire
);

    logic [7:0]  div_q;
    logic        tick;
    logic [31:0] cnt_q;
    logic        run_q;

    // Microsecond enable; restarted with the timer so the first tick is a full period.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 8'h00;
        end else if (start || tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign tick = (div_q == 8'(`SCS_TICK_CYC - 1));

    // Counts ticks while armed and fires once at the limit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 32'h0000_0000;
            run_q  <= 1'b0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (start) begin
                cnt_q <= 32'h0000_0000;
                run_q <= 1'b1;
            end else if (stop) begin
                run_q <= 1'b0;
            end else if (run_q && tick) begin
                if (cnt_q == 32'(LIMIT_US - 1)) begin
                    run_q  <= 1'b0;
                    expire <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 32'h0000_0001;
                end
            end
        end
    end

endmodule

// ### hdl/scs_sequencer.sv
// Function
// R1 - Clear command byte once a command is seen.
// R2 - Completion is shown by flags and state.
// R3 - Open initialises socket in selected protocol.
// R4 - Listen, TCP only: initialised goes to listening.
// R5 - Accepted client request sets flag 0, connected.
// R6 - Failed SYN/ACK sets timeout flag 3, closed.
// R7 - SYN to unserved port gets reset, no change.
// R8 - Connect, TCP only: send SYN to destination.
// R9 - SYN/ACK while connecting sets flag 0, connected.
// R10 - Resolution failure or no SYN/ACK: timeout flag.
// R11 - Reset answer to SYN fails the connection.
// R12 - Disconnect, TCP only: send FIN actively.
// R13 - Peer FIN is answered with own FIN.
// R14 - Protocol field 0001 selects TCP operation.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`include "scs_consts.svh"

module scs_sequencer
    import scs_pkg::*;
#(
    parameter int unsigned TCP_TIMEOUT_US = `SCS_TCP_TIMEOUT_US
) (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [11:0] ADR_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    input  wire logic        WE_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    output logic             ACK_O,
    input  wire logic        RX_SYN,
    input  wire logic        RX_PORT_HIT,
    input  wire logic        RX_SYNACK,
    input  wire logic        RX_ACK,
    input  wire logic        RX_RST,
    input  wire logic        RX_FIN,
    input  wire logic        ARP_DONE,
    input  wire logic        ARP_FAIL,
    input  wire logic        TX_FAIL,
    output logic             TX_SYN,
    output logic             TX_SYNACK,
    output logic             TX_FIN,
    output logic             TX_RST,
    output logic             ARP_REQ,
    output logic      [31:0] DEST_IP,
    output logic      [15:0] DEST_PORT
);

    logic [15:0] mode_q;
    logic [7:0]  cmd_q;
    logic [7:0]  iflag_q;
    scs_state_t  state_q;
    scs_state_t  state_d;
    logic [7:0]  state_code;
    logic [9:0]  idx;
    logic        wr_en;
    logic        is_tcp;
    logic [7:0]  set_if;
    logic        syn_d;
    logic        synack_d;
    logic        fin_d;
    logic        rst_d;
    logic        arp_d;
    logic        tmr_start;
    logic        tmr_stop;
    logic        tmr_expire;
    logic [31:0] rd_data;

    // Bus decode; a write lands on the edge at which the master sees the acknowledge.
    // Only the two byte-offset bits are ignored; every index bit is decoded.
    assign idx    = ADR_I[11:2];
    assign wr_en  = CYC_I && STB_I && WE_I && ACK_O;
    assign is_tcp = (mode_q[`SCS_PROTO_MSB:`SCS_PROTO_LSB] == `SCS_PROTO_TCP); // R14

    // Single-wait acknowledge; it drops in the cycle after it was given.
    // A master that holds its strobe past the acknowledge is answered every other cycle.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= CYC_I && STB_I && !ACK_O;
        end
    end

    // Read multiplexer; unmapped words are acknowledged and read as zero.
    // Its result is registered below, so this path never drives the bus directly.
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (idx)
            `SCS_IDX_MODE:  rd_data = {16'h0000, mode_q};
            `SCS_IDX_CMD:   rd_data = {24'h00_0000, cmd_q};
            `SCS_IDX_IFLAG: rd_data = {24'h00_0000, iflag_q};
            `SCS_IDX_STATE: rd_data = {24'h00_0000, state_code}; // R2
            `SCS_IDX_DPORT: rd_data = {16'h0000, DEST_PORT};
            `SCS_IDX_DIP:   rd_data = DEST_IP;
            default:        rd_data = 32'h0000_0000;
        endcase
    end

    // Read data is captured with the acknowledge so it is stable while ack is high.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DAT_O <= 32'h0000_0000;
        end else if (CYC_I && STB_I && !WE_I && !ACK_O) begin
            DAT_O <= rd_data;
        end
    end

    // Mode register; only implemented bits are kept so reserved bits read zero.
    // Software can still set bits 5, 7 and 8, which are kept although the sequencer never acts on them.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_q <= `SCS_MODE_RST;
        end else if (wr_en && idx == `SCS_IDX_MODE) begin
            if (SEL_I[0]) begin
                mode_q[7:0] <= DAT_I[7:0] & 8'(`SCS_MODE_MASK);
            end
            if (SEL_I[1]) begin
                mode_q[15:8] <= DAT_I[15:8] & 8'(`SCS_MODE_MASK >> 8);
            end
        end
    end

    // Destination address, one byte lane per select bit; the connect sequence reads it.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DEST_IP <= 32'h0000_0000;
        end else if (wr_en && idx == `SCS_IDX_DIP) begin
            for (int b = 0; b < 4; b++) begin
                if (SEL_I[b]) begin
                    DEST_IP[b*8 +: 8] <= DAT_I[b*8 +: 8];
                end
            end
        end
    end

    // Destination port on lanes 0 and 1; the upper lanes of the word are ignored.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DEST_PORT <= 16'h0000;
        end else if (wr_en && idx == `SCS_IDX_DPORT) begin
            for (int b = 0; b < 2; b++) begin
                if (SEL_I[b]) begin
                    DEST_PORT[b*8 +: 8] <= DAT_I[b*8 +: 8];
                end
            end
        end
    end

    // Command byte; any nonzero code is consumed the cycle after it lands, so a
    // zero readback only means accepted, not finished.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cmd_q <= `SCS_CMD_NONE;
        end else if (wr_en && idx == `SCS_IDX_CMD && SEL_I[0]) begin
            cmd_q <= DAT_I[7:0];
        end else if (cmd_q != `SCS_CMD_NONE) begin
            cmd_q <= `SCS_CMD_NONE; // R1
        end
    end

    // Sticky flags, cleared by writing ones; a new event in the same cycle wins.
    // Letting the set win means a clearing write can never erase an event raised in its own cycle.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            iflag_q <= `SCS_IFLAG_RST;
        end else if (wr_en && idx == `SCS_IDX_IFLAG && SEL_I[0]) begin
            iflag_q <= (iflag_q & ~DAT_I[7:0]) | set_if;
        end else begin
            iflag_q <= iflag_q | set_if;
        end
    end

    // Connection sequencer: next state, segment requests and flag events.
    always_comb begin
        state_d   = state_q;
        set_if    = 8'h00;
        syn_d     = 1'b0;
        synack_d  = 1'b0;
        fin_d     = 1'b0;
        rst_d     = 1'b0;
        arp_d     = 1'b0;
        tmr_start = 1'b0;
        tmr_stop  = 1'b0;
        // A SYN for a port nobody serves is refused without touching this socket.
        if (RX_SYN && !RX_PORT_HIT) begin
            rst_d = 1'b1; // R7
        end
        unique case (state_q)
            SCS_CLOSED, SCS_OTHER: begin
                if (cmd_q == `SCS_CMD_OPEN) begin
                    if (is_tcp) begin
                        state_d = SCS_INIT; // R3
                    end else if (mode_q[3:0] != `SCS_PROTO_CLOSED) begin
                        state_d = SCS_OTHER; // R3
                    end else begin
                        state_d = SCS_CLOSED;
                    end
                end
            end
            SCS_INIT: begin
                if (cmd_q == `SCS_CMD_LISTEN && is_tcp) begin
                    state_d = SCS_LISTEN; // R4
                end else if (cmd_q == `SCS_CMD_CONNECT && is_tcp) begin
                    state_d   = SCS_ARP; // R8
                    arp_d     = 1'b1;
                    tmr_start = 1'b1;
                end
            end
            SCS_LISTEN: begin
                if (RX_SYN && RX_PORT_HIT) begin
                    state_d   = SCS_SYNRECV;
                    synack_d  = 1'b1;
                    tmr_start = 1'b1;
                end
            end
            SCS_SYNRECV: begin
                if (TX_FAIL || tmr_expire) begin
                    state_d                = SCS_CLOSED; // R6
                    set_if[`SCS_IF_TIMEOUT] = 1'b1;
                    tmr_stop               = 1'b1;
                end else if (RX_ACK) begin
                    state_d            = SCS_ESTAB; // R5
                    set_if[`SCS_IF_CON] = 1'b1;
                    tmr_stop           = 1'b1;
                end
            end
            SCS_ARP: begin
                if (ARP_FAIL || tmr_expire) begin
                    state_d                = SCS_CLOSED; // R10
                    set_if[`SCS_IF_TIMEOUT] = 1'b1;
                    tmr_stop               = 1'b1;
                end else if (ARP_DONE) begin
                    state_d   = SCS_SYNSENT; // R8
                    syn_d     = 1'b1;
                    tmr_start = 1'b1;
                end
            end
            SCS_SYNSENT: begin
                if (RX_SYNACK) begin
                    state_d            = SCS_ESTAB; // R9
                    set_if[`SCS_IF_CON] = 1'b1;
                    tmr_stop           = 1'b1;
                end else if (RX_RST) begin
                    state_d               = SCS_CLOSED; // R11
                    set_if[`SCS_IF_DISCONNECT_COMMAND] = 1'b1;
                    tmr_stop              = 1'b1;
                end else if (tmr_expire) begin
                    state_d                = SCS_CLOSED; // R10
                    set_if[`SCS_IF_TIMEOUT] = 1'b1;
                end
            end
            SCS_ESTAB: begin
                if (cmd_q == `SCS_CMD_DISCONNECT_COMMAND && is_tcp) begin
                    state_d   = SCS_FINWAIT; // R12
                    fin_d     = 1'b1;
                    tmr_start = 1'b1;
                end else if (RX_FIN) begin
                    state_d   = SCS_LASTACK; // R13
                    fin_d     = 1'b1;
                    tmr_start = 1'b1;
                end else if (RX_RST) begin
                    state_d               = SCS_CLOSED;
                    set_if[`SCS_IF_DISCONNECT_COMMAND] = 1'b1;
                end
            end
            SCS_FINWAIT, SCS_LASTACK: begin
                // The peer's FIN, its final ACK or a reset ends the close handshake.
                if (RX_FIN || RX_ACK || RX_RST) begin
                    state_d               = SCS_CLOSED;
                    set_if[`SCS_IF_DISCONNECT_COMMAND] = 1'b1;
                    tmr_stop              = 1'b1;
                end else if (tmr_expire) begin
                    state_d                = SCS_CLOSED;
                    set_if[`SCS_IF_TIMEOUT] = 1'b1;
                end
            end
            // An upset into an unused code falls back to closed rather than locking up.
            default: begin
                state_d = SCS_CLOSED;
            end
        endcase
    end

    // State register.
    // Illegal codes cannot persist, since the next-state default returns to closed.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= SCS_CLOSED;
        end else begin
            state_q <= state_d;
        end
    end

    // Segment and resolution requests to the packet engine, one-cycle pulses.
    // They are registered so the packet engine sees clean single-cycle requests.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            TX_SYN    <= 1'b0;
            TX_SYNACK <= 1'b0;
            TX_FIN    <= 1'b0;
            TX_RST    <= 1'b0;
            ARP_REQ   <= 1'b0;
        end else begin
            TX_SYN    <= syn_d;
            TX_SYNACK <= synack_d;
            TX_FIN    <= fin_d;
            TX_RST    <= rst_d;
            ARP_REQ   <= arp_d;
        end
    end

    // Software-visible state code.
    always_comb begin
        unique case (state_q)
            SCS_CLOSED:  state_code = `SCS_ST_CLOSED;
            SCS_INIT:    state_code = `SCS_ST_INIT;
            SCS_OTHER:   state_code = `SCS_ST_OTHER;
            SCS_LISTEN:  state_code = `SCS_ST_LISTEN;
            SCS_SYNRECV: state_code = `SCS_ST_SYNRECV;
            SCS_ARP:     state_code = `SCS_ST_ARP;
            SCS_SYNSENT: state_code = `SCS_ST_SYNSENT;
            SCS_ESTAB:   state_code = `SCS_ST_ESTAB;
            SCS_FINWAIT: state_code = `SCS_ST_FINWAIT;
            SCS_LASTACK: state_code = `SCS_ST_LASTACK;
            default:     state_code = `SCS_ST_CLOSED;
        endcase
    end

    // One shared timer covers every handshake wait; only one is ever open.
    // Its expiry is a single pulse that only the waiting state acts on.
    scs_timer #(
        .LIMIT_US (TCP_TIMEOUT_US)
    ) scs_timer_i (
        .clk    (CLK),
        .rst_n  (RSTN),
        .start  (tmr_start),
        .stop   (tmr_stop),
        .expire (tmr_expire)
    );

endmodule

// ### verif/scs_sequencer_checker.sv
`timescale 1ns/100ps
`include "scs_consts.svh"
// Port-level checks of the sequencer; one clock domain, so defaults are shared.
module scs_sequencer_checker (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic [11:0] ADR_I,
    input wire logic [31:0] DAT_O,
    input wire logic        WE_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        ACK_O,
    input wire logic        RX_SYN,
    input wire logic        RX_PORT_HIT,
    input wire logic        RX_FIN,
    input wire logic        ARP_DONE,
    input wire logic        TX_SYN,
    input wire logic        TX_SYNACK,
    input wire logic        TX_FIN,
    input wire logic        TX_RST,
    input wire logic        ARP_REQ
);
    logic cmd_wr;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // A command write completes at the edge where ACK_O is seen high.
    assign cmd_wr = ACK_O && WE_I && (ADR_I[11:2] == `SCS_IDX_CMD);

    a_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack lasted more than one cycle");
    a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("bus request not answered next cycle");
    a_rst_reply: assert property (RX_SYN && !RX_PORT_HIT |=> TX_RST)
        else $error("no reset sent for unserved port");
    a_rst_cause: assert property (TX_RST |-> $past(RX_SYN && !RX_PORT_HIT))
        else $error("reset sent without cause");
    a_synack_cause: assert property (TX_SYNACK |-> $past(RX_SYN && RX_PORT_HIT))
        else $error("syn-ack sent without request");
    a_syn_after_arp: assert property (TX_SYN |-> $past(ARP_DONE))
        else $error("syn sent before address resolved");
    a_arp_from_cmd: assert property (ARP_REQ |-> $past(cmd_wr, 2))
        else $error("resolution request without command");
    a_fin_cause: assert property (TX_FIN |-> $past(RX_FIN) || $past(cmd_wr, 2))
        else $error("fin sent without cause");
    a_unmapped_zero: assert property (ACK_O && !WE_I && ADR_I[11:2] == 10'h3ff
        |-> DAT_O == 32'h0)
        else $error("unmapped read not zero");

    c_synack: cover property (TX_SYNACK);
    c_fin: cover property (TX_FIN);
    c_rst: cover property (TX_RST);
endmodule

// ### verif/scs_link_model.sv
`timescale 1ns/100ps
// Far-end peer and resolver: answers each request lag+1 cycles after it is seen.
// behav: 0 answers fully, 1 fails resolution, 2 resets the syn, 3 resolves, then answers neither syn nor syn-ack.
module scs_link_model (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [1:0] behav,
    input wire logic [3:0] lag,
    input wire logic       arp_req,
    input wire logic       tx_syn,
    input wire logic       tx_synack,
    input wire logic       tx_fin,
    output logic           arp_done,
    output logic           arp_fail,
    output logic           rx_synack,
    output logic           rx_ack,
    output logic           rx_rst
);
    logic [2:0] kind_q;
    logic [3:0] cnt_q;
    logic       busy_q;

    // One outstanding request at a time, since the sequencer never overlaps them.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {kind_q, cnt_q, busy_q} <= '0;
            {arp_done, arp_fail, rx_synack, rx_ack, rx_rst} <= '0;
        end else begin
            {arp_done, arp_fail, rx_synack, rx_ack, rx_rst} <= '0;
            if (arp_req || tx_syn || tx_synack || tx_fin) begin
                kind_q <= {arp_req, tx_syn, tx_synack && behav == 2'h0 || tx_fin};
                cnt_q  <= lag;
                busy_q <= 1'b1;
            end else if (busy_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (busy_q) begin
                busy_q    <= 1'b0;
                arp_done  <= kind_q[2] && behav != 2'h1;
                arp_fail  <= kind_q[2] && behav == 2'h1;
                rx_synack <= kind_q[1] && behav == 2'h0;
                rx_rst    <= kind_q[1] && behav == 2'h2;
                rx_ack    <= kind_q[0];
            end
        end
    end
endmodule

// ### verif/scs_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "scs_consts.svh"
module scs_sequencer_tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  ev = 4'h0;
    logic [1:0]  behav = 2'h0;
    logic [3:0]  lag = 4'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic [31:0] dip;
    logic [15:0] dport;
    logic        ack;
    logic        synack, rxack, rxrst, arpd, arpf;
    logic        tsyn, tsynack, tfin, trst, areq;
    int          bad_count = 0;
    int          checks = 0;
    int          n_rst = 0;
    int          n_fin = 0;

    // Free-running 50 MHz clock.
    initial forever #10 clk = ~clk;

    // Counts reset and FIN request pulses, which stand for one cycle only.
    always @(posedge clk) begin
        n_rst <= n_rst + trst;
        n_fin <= n_fin + tfin;
    end

    scs_sequencer #(.TCP_TIMEOUT_US(2)) scs_sequencer_i (
        .CLK(clk), .RSTN(rstn), .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat), .WE_I(we),
        .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .RX_SYN(ev[0]),
        .RX_PORT_HIT(ev[1]), .RX_SYNACK(synack), .RX_ACK(rxack), .RX_RST(rxrst),
        .RX_FIN(ev[2]), .ARP_DONE(arpd), .ARP_FAIL(arpf), .TX_FAIL(ev[3]),
        .TX_SYN(tsyn), .TX_SYNACK(tsynack), .TX_FIN(tfin), .TX_RST(trst),
        .ARP_REQ(areq), .DEST_IP(dip), .DEST_PORT(dport));

    scs_link_model scs_link_model_i (
        .clk(clk), .rst_n(rstn), .behav(behav), .lag(lag), .arp_req(areq),
        .tx_syn(tsyn), .tx_synack(tsynack), .tx_fin(tfin), .arp_done(arpd),
        .arp_fail(arpf), .rx_synack(synack), .rx_ack(rxack), .rx_rst(rxrst));

    task results;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic cycle: request held until ack is sampled, data taken at that edge.
    task wb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'hf};
        adr  <= {idx, 2'b00};
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        {cyc, stb, we} <= 3'b000;
        if (n >= 20) begin
            bad_count++;
            results;
        end
    endtask

    task rdchk(input logic [9:0] idx, input logic [31:0] exp, input string what);
        wb(1'b0, idx, 32'h0);
        cmp(what, exp, rd);
    endtask

    // Completion is judged by polling the state code, under a bound.
    task wait_st(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            wb(1'b0, `SCS_IDX_STATE, 32'h0);
            n++;
        end while (rd[7:0] !== exp && n < 300);
        cmp("state", {24'h0, exp}, rd);
        if (rd[7:0] !== exp) begin
            results;
        end
    endtask

    task flags(input logic [7:0] exp);
        rdchk(`SCS_IDX_IFLAG, {24'h0, exp}, "flags");
        wb(1'b1, `SCS_IDX_IFLAG, 32'h0b);
    endtask

    task pulse(input logic [3:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 4'h0;
    endtask

    task cmd(input logic [7:0] c);
        wb(1'b1, `SCS_IDX_CMD, {24'h0, c});
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rdchk(`SCS_IDX_MODE, 32'h0, "mode");
        rdchk(`SCS_IDX_STATE, 32'h0, "state");
        rdchk(`SCS_IDX_IFLAG, 32'h0, "flags");
        wb(1'b1, 10'h3ff, 32'hffff_ffff);
        rdchk(10'h3ff, 32'h0, "unmapped");
        wb(1'b1, `SCS_IDX_MODE, 32'hffff);
        rdchk(`SCS_IDX_MODE, {16'h0, `SCS_MODE_MASK}, "mode");
        $display("test registers done");
        wb(1'b1, `SCS_IDX_MODE, 32'h0);
        cmd(`SCS_CMD_OPEN);
        rdchk(`SCS_IDX_CMD, 32'h0, "command");
        rdchk(`SCS_IDX_STATE, 32'h0, "state");
        wb(1'b1, `SCS_IDX_MODE, 32'h2);
        cmd(`SCS_CMD_OPEN);
        wait_st(`SCS_ST_OTHER);
        cmd(`SCS_CMD_LISTEN);
        rdchk(`SCS_IDX_STATE, {24'h0, `SCS_ST_OTHER}, "state");
        wb(1'b1, `SCS_IDX_MODE, 32'h1);
        cmd(`SCS_CMD_OPEN);
        wait_st(`SCS_ST_INIT);
        pulse(4'b0001);
        rdchk(`SCS_IDX_STATE, {24'h0, `SCS_ST_INIT}, "state");
        cmp("resets", 32'h1, n_rst);
        cmd(`SCS_CMD_LISTEN);
        wait_st(`SCS_ST_LISTEN);
        pulse(4'b0011);
        wait_st(`SCS_ST_ESTAB);
        flags(8'h01);
        cmd(`SCS_CMD_DISCONNECT_COMMAND);
        wait_st(`SCS_ST_CLOSED);
        flags(8'h02);
        cmp("fins", 32'h1, n_fin);
        behav <= 2'h3;
        cmd(`SCS_CMD_OPEN);
        cmd(`SCS_CMD_LISTEN);
        wait_st(`SCS_ST_LISTEN);
        pulse(4'b0011);
        wait_st(`SCS_ST_SYNRECV);
        pulse(4'b1000);
        wait_st(`SCS_ST_CLOSED);
        flags(8'h08);
        $display("test server done");
        for (int i = 0; i < 4; i++) begin
            behav <= i[1:0];
            lag   <= (i == 0) ? 4'h6 : 4'h1;
            wb(1'b1, `SCS_IDX_DPORT, 32'h1f90 + i);
            wb(1'b1, `SCS_IDX_DIP, 32'hc0a8_0a02);
            cmd(`SCS_CMD_OPEN);
            wait_st(`SCS_ST_INIT);
            cmd(`SCS_CMD_CONNECT);
            cmp("dest port", 32'h1f90 + i, {16'h0, dport});
            cmp("dest ip", 32'hc0a8_0a02, dip);
            wait_st((i == 0) ? `SCS_ST_ESTAB : `SCS_ST_CLOSED);
            flags((i == 0) ? 8'h01 : (i == 2) ? 8'h02 : 8'h08);
            if (i == 2) begin
                rdchk(`SCS_IDX_STATE, {24'h0, `SCS_ST_CLOSED}, "state");
            end
            if (i == 0) begin
                pulse(4'b0100);
                wait_st(`SCS_ST_CLOSED);
                cmp("fins", 32'h2, n_fin);
                flags(8'h02);
            end
        end
        $display("test client done");
        results;
    end
endmodule

bind scs_sequencer scs_sequencer_checker scs_sequencer_checker_i (
    .CLK(CLK), .RSTN(RSTN), .ADR_I(ADR_I), .DAT_O(DAT_O), .WE_I(WE_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .RX_SYN(RX_SYN),
    .RX_PORT_HIT(RX_PORT_HIT), .RX_FIN(RX_FIN), .ARP_DONE(ARP_DONE),
    .TX_SYN(TX_SYN), .TX_SYNACK(TX_SYNACK), .TX_FIN(TX_FIN), .TX_RST(TX_RST),
    .ARP_REQ(ARP_REQ));
